/* rtl/rfcrc_top.sv */
// Transmit framing with CRC append, receive CRC check and forwarding, APB registers.
// Assumes byte source and bit demodulator run on clk; one bit per rx_bit_valid pulse.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps

module rfcrc_top
   import rfcrc_pkg::*;
#(
   parameter int unsigned BIT_CLKS = rfcrc_pkg::DEF_BIT_CLKS
)(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // APB slave
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pwrite,
   input  wire logic [7:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic            pready,
   output logic [31:0]     prdata,
   output logic            pslverr,
   // Transmit byte source
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_data_valid,
   input  wire logic       tx_data_last,
   output logic            tx_data_ready,
   // Modulation output
   output logic            tx_mod,
   // Receive bit stream
   input  wire logic       rx_bit,
   input  wire logic       rx_bit_valid,
   input  wire logic       rx_frame_end,
   // Receive bytes towards the buffer
   output logic [7:0]      rx_byte,
   output logic            rx_byte_valid
);

   localparam logic [15:0] BIT_LAST = 16'(BIT_CLKS - 1);
   localparam logic [15:0] QUARTER  = 16'(BIT_CLKS / 4);

   // Polynomial of a kind; reserved code behaves as CRC16
   function automatic logic [15:0] crc_poly(input logic [1:0] kind);
      crc_poly = (kind == RFCRC_KIND_CRC5) ? POLY_CRC5 :
                 (kind == RFCRC_KIND_CRC8) ? POLY_CRC8 : POLY_CRC16;
   endfunction

   function automatic logic [15:0] crc_mask(input logic [1:0] kind);
      crc_mask = (kind == RFCRC_KIND_CRC5) ? MASK_CRC5 :
                 (kind == RFCRC_KIND_CRC8) ? MASK_CRC8 : MASK_CRC16;
   endfunction

   function automatic logic [4:0] crc_width(input logic [1:0] kind);
      crc_width = (kind == RFCRC_KIND_CRC5) ? 5'd5 :
                  (kind == RFCRC_KIND_CRC8) ? 5'd8 : 5'd16;
   endfunction

   // One LSB-first step of a reflected CRC
   function automatic logic [15:0] crc_step(input logic [1:0] kind,
                                            input logic [15:0] c,
                                            input logic b);
      logic [15:0] r;
      r = {1'b0, c[15:1]};
      if (c[0] ^ b)
      begin
         r = r ^ crc_poly(kind);
      end
      crc_step = r & crc_mask(kind);
   endfunction

   // Seed table; codes four and five give zero
   function automatic logic [15:0] seed_val(input logic [1:0] kind,
                                            input logic [2:0] sel,
                                            input logic [15:0] user);
      logic [15:0] v;
      logic        k16;
      logic        k8;
      k16 = (kind != RFCRC_KIND_CRC5) && (kind != RFCRC_KIND_CRC8);
      k8  = (kind == RFCRC_KIND_CRC8);
      case (sel)
         3'h1:    v = k16 ? SEED16_C1 : (k8 ? SEED8_C1 : SEED5_C1);
         3'h2:    v = k16 ? SEED16_C2 : (k8 ? SEED8_C2 : 16'h0000);
         3'h3:    v = k16 ? SEED16_C3 : (k8 ? SEED8_C3 : 16'h0000);
         3'h6:    v = user;
         3'h7:    v = 16'hffff;
         default: v = 16'h0000;
      endcase
      seed_val = v & crc_mask(kind);
   endfunction

   // Registers
   logic [7:0]         tx_setup_q;
   logic [7:0]         rx_setup_q;
   logic [7:0]         frame_q;
   logic [7:0]         width_q;
   logic [7:0]         ctrl_q;
   logic [15:0]        user_seed_q;
   logic               crc_err_q;
   logic               pready_q;
   logic               pslverr_q;
   logic [31:0]        prdata_q;

   // Transmit state
   rfcrc_tx_state_type tx_state_q;
   rfcrc_tx_state_type tx_state_d;
   logic [15:0]        bc_q;
   logic [15:0]        grid_q;
   logic [7:0]         byte_q;
   logic [3:0]         bits_left_q;
   logic               last_q;
   logic [15:0]        crc_tx_q;
   logic [15:0]        crc_sh_q;
   logic [4:0]         crc_left_q;
   logic               ready_q;
   logic               mod_q;

   // Receive state
   logic [15:0]        hist_q;
   logic [4:0]         rx_cnt_q;
   logic [15:0]        rx_crc_q;
   logic [7:0]         asm_q;
   logic [3:0]         asm_n_q;
   logic [7:0]         rx_byte_q;
   logic               rx_byte_valid_q;

   // Field views
   wire logic          tx_append_en   = tx_setup_q[CRC_EN_BIT];
   wire logic          tx_compl       = tx_setup_q[CRC_COMPL_BIT];
   wire logic [1:0]    tx_kind        = tx_setup_q[CRC_KIND_LSB +: 2];
   wire logic [2:0]    tx_seed_sel    = tx_setup_q[CRC_SEED_LSB +: 3];
   wire logic          rx_check_en    = rx_setup_q[CRC_EN_BIT];
   wire logic          rx_compl       = rx_setup_q[CRC_COMPL_BIT];
   wire logic [1:0]    rx_kind        = rx_setup_q[CRC_KIND_LSB +: 2];
   wire logic [2:0]    rx_seed_sel    = rx_setup_q[CRC_SEED_LSB +: 3];
   wire logic          rx_fwd         = rx_setup_q[RX_FWD_BIT];
   wire logic [2:0]    final_bits     = frame_q[FRM_BITS_LSB +: 3];
   wire logic          payload_en     = frame_q[FRM_PAYLOAD_BIT];
   wire logic          grid_align     = frame_q[FRM_GRID_BIT];
   wire logic          miller_sel     = ctrl_q[CTRL_MILLER_BIT];
   wire logic [1:0]    pulse_pos      = ctrl_q[CTRL_POS_LSB +: 2];

   // APB decode
   wire logic [5:0]    idx      = paddr[7:2];
   wire logic          setup_ph = psel & penable & ~pready_q;
   wire logic          acc      = psel & penable & pready_q;
   wire logic          hit      = (idx == IDX_TX_CRC_SETUP) || (idx == IDX_RX_CRC_SETUP) ||
                                  (idx == IDX_TX_FRAME_LEN) || (idx == IDX_TX_PULSE_WIDTH) ||
                                  (idx == IDX_CTRL) || (idx == IDX_STATUS) ||
                                  (idx == IDX_USER_SEED);
   wire logic          wr       = acc & pwrite & ~pslverr_q;
   wire logic          wr_ctrl  = wr & (idx == IDX_CTRL);
   wire logic          start    = wr_ctrl & pwdata[CTRL_START_BIT] &
                                  (tx_state_q == RFCRC_TX_IDLE);
   wire logic          tx_busy  = (tx_state_q != RFCRC_TX_IDLE);
   wire logic          rx_busy  = (rx_cnt_q != 5'd0);

   // Read mux
   logic [31:0]        rdata;
   always_comb
   begin
      rdata = 32'h0000_0000;
      if (idx == IDX_TX_CRC_SETUP)
         rdata[7:0] = tx_setup_q;
      else if (idx == IDX_RX_CRC_SETUP)
         rdata[7:0] = rx_setup_q;
      else if (idx == IDX_TX_FRAME_LEN)
         rdata[7:0] = frame_q;
      else if (idx == IDX_TX_PULSE_WIDTH)
         rdata[7:0] = width_q;
      else if (idx == IDX_CTRL)
         rdata[7:0] = ctrl_q;
      else if (idx == IDX_STATUS)
         rdata[2:0] = {rx_busy, tx_busy, crc_err_q};
      else if (idx == IDX_USER_SEED)
         rdata[15:0] = user_seed_q;
   end

   // APB answer one cycle into the access phase
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
      else
      begin
         pready_q  <= setup_ph;
         pslverr_q <= setup_ph & ~hit;
         prdata_q  <= (setup_ph & ~pwrite & hit) ? rdata : 32'h0000_0000;
      end
   end

   // Software registers; the hardware error set wins over its clear
   wire logic          err_set;
   wire logic          err_clr = wr & (idx == IDX_STATUS) & pwdata[STAT_ERR_BIT];
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_setup_q  <= RST_REG8;
         rx_setup_q  <= RST_REG8;
         frame_q     <= RST_REG8;
         width_q     <= RST_REG8;
         ctrl_q      <= RST_REG8;
         user_seed_q <= RST_USER_SEED;
         crc_err_q   <= 1'b0;
      end
      else
      begin
         if (wr && idx == IDX_TX_CRC_SETUP)   tx_setup_q  <= pwdata[7:0] & TX_SETUP_MASK;
         if (wr && idx == IDX_RX_CRC_SETUP)   rx_setup_q  <= pwdata[7:0];
         if (wr && idx == IDX_TX_FRAME_LEN)   frame_q     <= pwdata[7:0] & FRAME_MASK;
         if (wr && idx == IDX_TX_PULSE_WIDTH) width_q     <= pwdata[7:0];
         if (wr_ctrl)                         ctrl_q      <= pwdata[7:0] & CTRL_MASK;
         if (wr && idx == IDX_USER_SEED)      user_seed_q <= pwdata[15:0];
         crc_err_q <= err_set | (crc_err_q & ~err_clr);
      end
   end

   // Transmit bit timing and sequencing
   wire logic          bit_end    = (bc_q == BIT_LAST);
   wire logic          grid_end   = (grid_q == BIT_LAST);
   wire logic          take       = ready_q & tx_data_valid;
   wire logic [15:0]   crc_next   = crc_step(tx_kind, crc_tx_q, byte_q[0]);
   wire logic [15:0]   crc_final  = (tx_compl ? ~crc_next : crc_next) & crc_mask(tx_kind);
   wire logic [3:0]    load_bits  = (tx_data_last && final_bits != 3'b000) ?
                                    {1'b0, final_bits} : 4'd8;
   wire logic          last_bit   = (bits_left_q == 4'd1);
   wire rfcrc_tx_state_type first_st = payload_en ? RFCRC_TX_LOAD : RFCRC_TX_SYM;

   always_comb
   begin
      tx_state_d = tx_state_q;
      case (tx_state_q)
         RFCRC_TX_IDLE:
            if (start)
               tx_state_d = grid_align ? RFCRC_TX_GRID : first_st;
         RFCRC_TX_GRID:
            if (grid_end)
               tx_state_d = first_st;
         RFCRC_TX_LOAD:
            if (take)
               tx_state_d = RFCRC_TX_SEND;
         RFCRC_TX_SEND:
            if (bit_end && last_bit)
               tx_state_d = !last_q ? RFCRC_TX_LOAD :
                            (tx_append_en ? RFCRC_TX_CRC : RFCRC_TX_IDLE);
         RFCRC_TX_CRC:
            if (bit_end && crc_left_q == 5'd1)
               tx_state_d = RFCRC_TX_IDLE;
         RFCRC_TX_SYM:
            if (bit_end)
               tx_state_d = RFCRC_TX_IDLE;
         default:
            tx_state_d = RFCRC_TX_IDLE;
      endcase
   end

   // Free-running unit grid, and bit timer restarted at each bit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_state_q <= RFCRC_TX_IDLE;
         grid_q     <= 16'h0000;
         bc_q       <= 16'h0000;
      end
      else
      begin
         tx_state_q <= tx_state_d;
         grid_q     <= grid_end ? 16'h0000 : grid_q + 16'h0001;
         bc_q       <= (bit_end || tx_state_d != tx_state_q) ? 16'h0000 : bc_q + 16'h0001;
      end
   end

   // Data path: byte shift LSB first, CRC accumulate, CRC shift out
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         byte_q      <= 8'h00;
         bits_left_q <= 4'd0;
         last_q      <= 1'b0;
         crc_tx_q    <= 16'h0000;
         crc_sh_q    <= 16'h0000;
         crc_left_q  <= 5'd0;
         ready_q     <= 1'b0;
      end
      else
      begin
         ready_q <= (tx_state_d == RFCRC_TX_LOAD) & ~take;
         if (start)
            crc_tx_q <= seed_val(tx_kind, tx_seed_sel, user_seed_q);
         if (take)
         begin
            byte_q      <= tx_data;
            bits_left_q <= load_bits;
            last_q      <= tx_data_last;
         end
         else if (tx_state_q == RFCRC_TX_SEND && bit_end)
         begin
            byte_q      <= {1'b0, byte_q[7:1]};
            bits_left_q <= bits_left_q - 4'd1;
            crc_tx_q    <= crc_next;
            if (last_bit && last_q)
            begin
               crc_sh_q   <= crc_final;
               crc_left_q <= crc_width(tx_kind);
            end
         end
         else if (tx_state_q == RFCRC_TX_CRC && bit_end)
         begin
            crc_sh_q   <= {1'b0, crc_sh_q[15:1]};
            crc_left_q <= crc_left_q - 5'd1;
         end
      end
   end

   // Pulse shaping: start position, width plus one, cut at bit end
   wire logic [15:0]   start_off = 16'(QUARTER * {14'h0000, pulse_pos});
   wire logic [15:0]   off       = bc_q - start_off;
   wire logic          in_win    = (bc_q >= start_off) && (off <= {8'h00, width_q});
   wire logic          cur_bit   = (tx_state_q == RFCRC_TX_SEND) ? byte_q[0] :
                                   (tx_state_q == RFCRC_TX_CRC)  ? crc_sh_q[0] :
                                   (tx_state_q == RFCRC_TX_SYM);
   wire logic          sending   = (tx_state_q == RFCRC_TX_SEND) ||
                                   (tx_state_q == RFCRC_TX_CRC) || (tx_state_q == RFCRC_TX_SYM);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mod_q <= 1'b0;
      else
         mod_q <= sending & cur_bit & (~miller_sel | in_win);
   end

   // Receive: last CRC-width bits held back, older bits fed to CRC
   wire logic [4:0]    rx_w     = crc_width(rx_kind);
   wire logic [4:0]    drop_idx = 5'd16 - rx_w;
   wire logic          rx_full  = (rx_cnt_q >= rx_w);
   wire logic          drop_bit = hist_q[drop_idx[3:0]];
   wire logic [15:0]   rx_seed  = seed_val(rx_kind, rx_seed_sel, user_seed_q);
   wire logic [15:0]   rx_recv  = hist_q >> drop_idx;
   wire logic [15:0]   rx_exp   = (rx_compl ? ~rx_crc_q : rx_crc_q) & crc_mask(rx_kind);
   assign err_set = rx_frame_end & rx_check_en & (~rx_full | (rx_recv != rx_exp));
   wire logic          asm_go   = rx_bit_valid & (rx_fwd | rx_full);
   wire logic          asm_bit  = rx_fwd ? rx_bit : drop_bit;
   wire logic [3:0]    pad_sh   = 4'd8 - asm_n_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hist_q   <= 16'h0000;
         rx_cnt_q <= 5'd0;
         rx_crc_q <= 16'h0000;
      end
      else if (rx_frame_end)
      begin
         hist_q   <= 16'h0000;
         rx_cnt_q <= 5'd0;
      end
      else if (rx_bit_valid)
      begin
         hist_q   <= {rx_bit, hist_q[15:1]};
         rx_cnt_q <= (rx_cnt_q == 5'd31) ? rx_cnt_q : rx_cnt_q + 5'd1;
         rx_crc_q <= rx_full ? crc_step(rx_kind, rx_crc_q, drop_bit) : rx_seed;
      end
   end

   // Byte assembly towards the buffer; a partial byte is flushed at frame end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         asm_q           <= 8'h00;
         asm_n_q         <= 4'd0;
         rx_byte_q       <= 8'h00;
         rx_byte_valid_q <= 1'b0;
      end
      else
      begin
         rx_byte_valid_q <= 1'b0;
         if (rx_frame_end)
         begin
            asm_n_q         <= 4'd0;
            rx_byte_q       <= asm_q >> pad_sh;
            rx_byte_valid_q <= (asm_n_q != 4'd0);
         end
         else if (asm_go)
         begin
            asm_q   <= {asm_bit, asm_q[7:1]};
            asm_n_q <= (asm_n_q == 4'd7) ? 4'd0 : asm_n_q + 4'd1;
            if (asm_n_q == 4'd7)
            begin
               rx_byte_q       <= {asm_bit, asm_q[7:1]};
               rx_byte_valid_q <= 1'b1;
            end
         end
      end
   end

   // Outputs
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign prdata        = prdata_q;
   assign tx_data_ready = ready_q;
   assign tx_mod        = mod_q;
   assign rx_byte       = rx_byte_q;
   assign rx_byte_valid = rx_byte_valid_q;

   // Helper: length of the current modulation pulse
   logic [8:0] mod_run_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mod_run_q <= 9'd0;
      else
         mod_run_q <= mod_q ? mod_run_q + 9'd1 : 9'd0;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_crc_append: assert property (
      (tx_state_q == RFCRC_TX_SEND && bit_end && last_bit && last_q && tx_append_en)
      |=> tx_state_q == RFCRC_TX_CRC)
      else $error("CRC not appended after last data bit");
   a_crc_invert: assert property (
      (tx_state_q == RFCRC_TX_SEND && tx_state_d == RFCRC_TX_CRC && tx_compl)
      |=> ((crc_sh_q ^ $past(crc_next)) == crc_mask(tx_kind)))
      else $error("Appended CRC not inverted");
   a_crc_length: assert property (
      $rose(tx_state_q == RFCRC_TX_CRC) |-> crc_left_q == crc_width(tx_kind))
      else $error("CRC bit count does not match kind");
   a_tx_seed: assert property (
      start |=> crc_tx_q == seed_val(tx_kind, tx_seed_sel, user_seed_q))
      else $error("Transmit CRC not seeded at frame start");
   a_rx_seed: assert property (
      (rx_bit_valid && !rx_full && !rx_frame_end) |=> rx_crc_q == $past(rx_seed))
      else $error("Receive CRC not seeded");
   a_err_gate: assert property (
      $rose(crc_err_q) |-> $past(rx_frame_end && rx_check_en))
      else $error("Error flag moved without checking");
   a_grid_start: assert property (
      (tx_state_q == RFCRC_TX_GRID && tx_state_d != RFCRC_TX_GRID) |-> grid_end)
      else $error("Aligned start off the unit grid");
   a_sym_only: assert property (
      (start && !payload_en && !grid_align) |=> tx_state_q == RFCRC_TX_SYM && !ready_q)
      else $error("Symbol-only frame requested data");
   a_trim_bits: assert property (
      (take && tx_data_last && final_bits != 3'b000) |=> bits_left_q == {1'b0, $past(final_bits)})
      else $error("Final byte bit count wrong");
   a_pulse_len: assert property (
      (miller_sel && $stable(width_q)) |-> mod_run_q <= {1'b0, width_q} + 9'd1)
      else $error("Pulse longer than width plus one");

   c_crc_sent: cover property ($rose(tx_state_q == RFCRC_TX_CRC));
   c_sym_sent: cover property ($rose(tx_state_q == RFCRC_TX_SYM));
   c_err_set:  cover property ($rose(crc_err_q));
   c_rx_byte:  cover property (rx_byte_valid_q && rx_fwd);

endmodule

/* rtl/rfcrc_pkg.sv */
// Constants, field layouts and state codes of the reader CRC and frame shaping block.
// Assumes one system clock; shared by the block and its bench.
package rfcrc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0]  IDX_TX_CRC_SETUP   = 6'h2c;
   localparam logic [5:0]  IDX_RX_CRC_SETUP   = 6'h2d;
   localparam logic [5:0]  IDX_TX_FRAME_LEN   = 6'h2e;
   localparam logic [5:0]  IDX_TX_PULSE_WIDTH = 6'h2f;
   localparam logic [5:0]  IDX_CTRL           = 6'h38;
   localparam logic [5:0]  IDX_STATUS         = 6'h39;
   localparam logic [5:0]  IDX_USER_SEED      = 6'h3a;

   // Field positions
   localparam int          CRC_EN_BIT         = 0;
   localparam int          CRC_COMPL_BIT      = 1;
   localparam int          CRC_KIND_LSB       = 2;
   localparam int          CRC_SEED_LSB       = 4;
   localparam int          RX_FWD_BIT         = 7;
   localparam int          FRM_BITS_LSB       = 0;
   localparam int          FRM_PAYLOAD_BIT    = 3;
   localparam int          FRM_GRID_BIT       = 4;
   localparam int          CTRL_START_BIT     = 0;
   localparam int          CTRL_MILLER_BIT    = 1;
   localparam int          CTRL_POS_LSB       = 2;
   localparam int          STAT_ERR_BIT       = 0;

   // Writable bits and reset values
   localparam logic [7:0]  TX_SETUP_MASK      = 8'h7f;
   localparam logic [7:0]  FRAME_MASK         = 8'h1f;
   localparam logic [7:0]  CTRL_MASK          = 8'h0e;
   localparam logic [7:0]  RST_REG8           = 8'h00;
   localparam logic [15:0] RST_USER_SEED      = 16'h0000;

   // Reflected polynomials and value masks
   localparam logic [15:0] POLY_CRC16         = 16'h8408;
   localparam logic [15:0] POLY_CRC8          = 16'h00b8;
   localparam logic [15:0] POLY_CRC5          = 16'h0012;
   localparam logic [15:0] MASK_CRC16         = 16'hffff;
   localparam logic [15:0] MASK_CRC8          = 16'h00ff;
   localparam logic [15:0] MASK_CRC5          = 16'h001f;

   // Seed table entries
   localparam logic [15:0] SEED16_C1          = 16'h6363;
   localparam logic [15:0] SEED16_C2          = 16'ha671;
   localparam logic [15:0] SEED16_C3          = 16'hfffe;
   localparam logic [15:0] SEED8_C1           = 16'h0012;
   localparam logic [15:0] SEED8_C2           = 16'h00bf;
   localparam logic [15:0] SEED8_C3           = 16'h00fd;
   localparam logic [15:0] SEED5_C1           = 16'h0012;

   // Carrier clocks per elementary time unit
   localparam int          DEF_BIT_CLKS       = 128;

   typedef enum logic [1:0] {
      RFCRC_KIND_CRC5  = 2'b00,
      RFCRC_KIND_CRC8  = 2'b01,
      RFCRC_KIND_CRC16 = 2'b10,
      RFCRC_KIND_RSVD  = 2'b11
   } rfcrc_kind_type;

   typedef enum logic [2:0] {
      RFCRC_TX_IDLE = 3'b000,
      RFCRC_TX_GRID = 3'b001,
      RFCRC_TX_LOAD = 3'b010,
      RFCRC_TX_SEND = 3'b011,
      RFCRC_TX_CRC  = 3'b100,
      RFCRC_TX_SYM  = 3'b101
   } rfcrc_tx_state_type;

endpackage

/* tb/rfcrc_card.sv */
// Card model: replies to the reader as a bit stream.
// Assumes the reader samples on the rising clock edge.
`timescale 1ns/10ps
module rfcrc_card
(
   // Clock
   input  wire logic clk,
   // Reply stream
   output logic      rx_bit = 1'b0,
   output logic      rx_bit_valid = 1'b0,
   output logic      rx_frame_end = 1'b0
);
   // Sends n bits with a gap after each; the line flips once not valid
   task automatic send(input logic [23:0] f, input int n);
      for (int i = 0; i < n; i++)
      begin
         rx_bit <= f[i];
         rx_bit_valid <= 1'b1;
         @(posedge clk);
         rx_bit <= ~f[i];
         rx_bit_valid <= 1'b0;
         @(posedge clk);
      end
      rx_frame_end <= 1'b1;
      @(posedge clk);
      rx_frame_end <= 1'b0;
   endtask
endmodule

/* tb/rfcrc_top_tb.sv */
// Bench: registers, receive CRC check, transmit shaping.
// Assumes the card model on the rx stream and BIT_CLKS of 8.
`timescale 1ns/10ps
module rfcrc_top_tb;
   import rfcrc_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic tx_data_valid = 1'b0, tx_data_last = 1'b0, err_q;
   logic [7:0] paddr = 8'h00, tx_data = 8'h00, rx_byte, last_byte;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, tx_data_ready, tx_mod, rx_bit, rx_bit_valid, rx_frame_end;
   logic rx_byte_valid;
   int mismatches = 0, checks_done = 0, cyc = 0, nbytes = 0;
   rfcrc_top #(.BIT_CLKS(8)) i_rfcrc_top (.clk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .tx_data, .tx_data_valid,
      .tx_data_last, .tx_data_ready, .tx_mod, .rx_bit, .rx_bit_valid, .rx_frame_end,
      .rx_byte, .rx_byte_valid);
   rfcrc_card i_rfcrc_card (.clk, .rx_bit, .rx_bit_valid, .rx_frame_end);
   initial forever #10 clk = ~clk;
   // Byte capture and hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (rx_byte_valid === 1'b1)
      begin
         nbytes <= nbytes + 1;
         last_byte <= rx_byte;
      end
      if (cyc == 20000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; holds the request until pready
   task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {a, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Reflected CRC over one byte, LSB first
   function automatic logic [15:0] crc(input logic [7:0] b, input logic [15:0] c, p);
      for (int i = 0; i < 8; i++)
         c = (c[0] ^ b[i]) ? (c >> 1) ^ p : c >> 1;
      return c;
   endfunction
   // Card sends 5Ah and a CRC; flag and forwarded bytes judged
   task automatic rx_case(input logic [7:0] cfg, input logic [15:0] sd, p, fl,
                          input int n, input logic err, input int nb);
      logic [15:0] c;
      int n0;
      c = crc(8'h5a, sd, p) ^ fl;
      apb(1'b1, IDX_RX_CRC_SETUP, {24'h0, cfg});
      apb(1'b1, IDX_STATUS, 32'h1);
      n0 = nbytes;
      i_rfcrc_card.send({c, 8'h5a}, n);
      repeat (4) @(posedge clk);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk(rd[0], err);
      chk(nbytes - n0, nb);
      chk(last_byte, (nb == 1) ? 8'h5a : (nb == 2) ? c[7:0] : c[15:8]);
   endtask
   // Sends B2h as last byte, samples tx_mod mid-bit
   task automatic tx_case(input logic [7:0] su, frm, input logic [23:0] exp);
      logic [23:0] got;
      apb(1'b1, IDX_TX_CRC_SETUP, {24'h0, su});
      apb(1'b1, IDX_TX_FRAME_LEN, {24'h0, frm});
      apb(1'b1, IDX_CTRL, 32'h1);
      tx_data <= 8'hb2;
      tx_data_last <= 1'b1;
      tx_data_valid <= 1'b1;
      do @(posedge clk); while (tx_data_ready !== 1'b1);
      tx_data_valid <= 1'b0;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 24; i++)
      begin
         got[i] = tx_mod;
         repeat (8) @(posedge clk);
      end
      chk(got, exp);
   endtask
   // Symbol-only frame; counts modulated cycles
   task automatic sym_case(input logic [31:0] frm, ctl, input int exp);
      int hi;
      hi = 0;
      apb(1'b1, IDX_TX_FRAME_LEN, frm);
      apb(1'b1, IDX_CTRL, ctl);
      repeat (40)
      begin
         @(posedge clk);
         hi += tx_mod;
      end
      chk(hi, exp);
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      logic [15:0] k;
      k = ~crc(8'hb2, 16'h0, POLY_CRC8);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, IDX_TX_CRC_SETUP, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, IDX_TX_CRC_SETUP, 32'hff);
      apb(1'b0, IDX_TX_CRC_SETUP, 32'h0);
      chk(rd, 32'h7f);
      apb(1'b0, 6'h00, 32'h0);
      chk(err_q, 1'b1);
      apb(1'b1, IDX_USER_SEED, 32'hbeef);
      rx_case(8'h19, SEED16_C1, POLY_CRC16, 16'h0, 24, 1'b0, 1);
      rx_case(8'h19, SEED16_C1, POLY_CRC16, 16'h1, 24, 1'b1, 1);
      rx_case(8'h18, SEED16_C1, POLY_CRC16, 16'h1, 24, 1'b0, 1);
      rx_case(8'h1b, SEED16_C1, POLY_CRC16, 16'hffff, 24, 1'b0, 1);
      rx_case(8'h99, SEED16_C1, POLY_CRC16, 16'h0, 24, 1'b0, 3);
      rx_case(8'h69, 16'hbeef, POLY_CRC16, 16'h0, 24, 1'b0, 1);
      rx_case(8'h25, SEED8_C2, POLY_CRC8, 16'h0, 16, 1'b0, 1);
      rx_case(8'hf1, MASK_CRC5, POLY_CRC5, 16'h0, 13, 1'b0, 2);
      tx_case(8'h00, 8'h0b, 24'h2);
      tx_case(8'h07, 8'h08, {8'h0, k[7:0], 8'hb2});
      apb(1'b1, IDX_TX_PULSE_WIDTH, 32'h2);
      sym_case(32'h0, 32'h1, 8);
      sym_case(32'h0, 32'h3, 3);
      sym_case(32'h0, 32'hf, 2);
      sym_case(32'h10, 32'h1, 8);
      tally_and_finish();
   end
endmodule
